// >>> rtl/fbpc_regs.vh
/*
 fbpc_regs.vh: constants for the fieldbus poll-cycle timer.
 assumes: included by bare name from rtl modules; 200 MHz system clock.
*/
`ifndef FBPC_REGS_VH
`define FBPC_REGS_VH
`define FBPC_CLK_MHZ 200
`define FBPC_BYTE_BITS 16'd11
`define FBPC_FRAME_OVH 16'd9
`define FBPC_REFRESH_US 32'd150
`define FBPC_COMPAT_REFRESH_US 32'd2000
`define FBPC_CYC_PER_US 32'd200
`define FBPC_RATE_9K6 4'h0
`define FBPC_RATE_19K2 4'h1
`define FBPC_RATE_93K75 4'h2
`define FBPC_RATE_187K5 4'h3
`define FBPC_RATE_500K 4'h4
`define FBPC_RATE_1M5 4'h5
`define FBPC_RATE_3M 4'h6
`define FBPC_RATE_6M 4'h7
`define FBPC_RATE_12M 4'h8
`define FBPC_TURN_LOW 16'd70
`define FBPC_TURN_500K 16'd150
`define FBPC_TURN_1M5 16'd200
`define FBPC_TURN_3M 16'd250
`define FBPC_TURN_6M 16'd450
`define FBPC_TURN_12M 16'd800
`define FBPC_FIFO_DEPTH 8
`define FBPC_FIFO_AW 3
`define FBPC_DW 8
`define FBPC_MAX_SLAVES 8
`define FBPC_SW 3
`endif

// >>> rtl/fbpc_fifo.v
/*
 fbpc_fifo.v: small synchronous fifo with valid/ready on both sides.
 assumes: single clock, async active-low reset; depth a power of two.
*/
`timescale 1ns/1ps
module fbpc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst_b,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire push;
  wire pop;

  ////////////////////////////////////////////////////////////////
  // full when pointers differ only in the wrap bit
  assign in_ready = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and storage update
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // storage has no reset: contents only read when valid
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

// >>> rtl/fbpc_poll_timer.v
/*
 fbpc_poll_timer.v: poll-cycle sequencer and timer for a fieldbus master.
 Polls each configured slave once per cycle, times request, slave delay,
 response and turnaround in bit times, adds the refresh time, stretches
 the cycle to the minimum poll interval and moves received bytes into
 host buffer memory through a fifo once per cycle.
 assumes: slave sizes and delays come as static inputs; the serial line
 itself lives elsewhere and only frame timing is modelled here.
*/
// Behaviour
// - cycle period is max of minimum interval and summed poll, turnaround, refresh
// - received data copied to host memory once per cycle period
// - request frame is output bytes plus nine, eleven bit times each
// - one bit time is reciprocal of rate; delays scale with rate
// - master turnaround 70/150/200/250/450/800 bit times by rate
// - refresh time is 150 us per configured slave
// - compatibility variant adds fixed 2 ms to refresh time
// - shared bus cycle is sum of all masters' cycle periods
`timescale 1ns/1ps
`include "fbpc_regs.vh"
module fbpc_poll_timer (
  input wire clk,
  input wire rst_b,
  input wire enable,
  input wire [3:0] rate_sel,
  input wire compat_mode,
  input wire [3:0] slave_count,
  input wire [31:0] min_poll_interval,
  input wire [63:0] out_bytes_flat,
  input wire [63:0] in_bytes_flat,
  input wire [127:0] max_delay_flat,
  input wire [31:0] other_masters_time,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire host_ready,
  output reg [2:0] cur_slave,
  output reg req_active,
  output reg resp_window,
  output reg cycle_start,
  output reg refresh_pulse,
  output reg [31:0] bus_cycle_time,
  output reg [31:0] multi_master_cycle_time,
  output reg [31:0] data_refresh_time,
  output reg [31:0] per_slave_poll_time,
  output reg host_valid,
  output reg [7:0] host_data,
  output reg rx_ready
);
  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_REQ = 6'b000010;
  localparam [5:0] ST_WAIT = 6'b000100;
  localparam [5:0] ST_RESP = 6'b001000;
  localparam [5:0] ST_TURN = 6'b010000;
  localparam [5:0] ST_REFR = 6'b100000;

  // clocks per bit, rounded up; 9.6k..12M at 200 MHz
  function [15:0] bit_clocks;
    input [3:0] sel;
    begin
      case (sel)
        4'd0: bit_clocks = 16'd20834;
        4'd1: bit_clocks = 16'd10417;
        4'd2: bit_clocks = 16'd2134;
        4'd3: bit_clocks = 16'd1067;
        4'd4: bit_clocks = 16'd400;
        4'd5: bit_clocks = 16'd134;
        4'd6: bit_clocks = 16'd67;
        4'd7: bit_clocks = 16'd34;
        4'd8: bit_clocks = 16'd17;
        default: bit_clocks = 16'd134;
      endcase
    end
  endfunction

  // master turnaround in bit times per rate
  function [15:0] turn_bits;
    input [3:0] sel;
    begin
      case (sel)
        4'd0, 4'd1, 4'd2, 4'd3: turn_bits = `FBPC_TURN_LOW;
        4'd4: turn_bits = `FBPC_TURN_500K;
        4'd5: turn_bits = `FBPC_TURN_1M5;
        4'd6: turn_bits = `FBPC_TURN_3M;
        4'd7: turn_bits = `FBPC_TURN_6M;
        4'd8: turn_bits = `FBPC_TURN_12M;
        default: turn_bits = `FBPC_TURN_LOW;
      endcase
    end
  endfunction

  reg [5:0] state;
  reg [15:0] bit_div;
  reg bit_tick;
  reg [15:0] bit_left;
  reg [31:0] cycle_cnt;
  reg [31:0] slave_cnt;
  reg [31:0] refr_left;
  reg copy_open;
  wire [7:0] cur_out = out_bytes_flat[cur_slave*8 +: 8];
  wire [7:0] cur_in = in_bytes_flat[cur_slave*8 +: 8];
  wire [15:0] cur_delay = max_delay_flat[cur_slave*16 +: 16];
  wire [7:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop = copy_open && (!host_valid || host_ready);
  wire [31:0] refresh_us = slave_count * `FBPC_REFRESH_US + (compat_mode ? `FBPC_COMPAT_REFRESH_US : 32'h0000_0000);
  wire last_slave = ({1'b0, cur_slave} + 4'd1) >= slave_count;
  // receive side: byte taken only on a registered ready, so level is mirrored here
  reg [3:0] rx_level;
  wire rx_push = rx_valid && rx_ready && resp_window;
  wire rx_pop = fifo_pop && fifo_valid;
  wire [3:0] next_rx_level = rx_level + {3'h0, rx_push} - {3'h0, rx_pop};

  ////////////////////////////////////////////////////////////////
  // bit-time tick
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_div <= 16'h0000;
      bit_tick <= 1'b0;
    end else if (state == ST_IDLE) begin
      // preloaded so the first bit of a frame is one full bit long
      bit_div <= 16'h0001;
      bit_tick <= 1'b0;
    end else if (bit_div + 16'd1 >= bit_clocks(rate_sel)) begin
      bit_div <= 16'h0000;
      bit_tick <= 1'b1;
    end else begin
      bit_div <= bit_div + 16'd1;
      bit_tick <= 1'b0;
    end
  end

  // receive buffer; back-pressure stalls the serial source
  fbpc_fifo #(
    .WIDTH(`FBPC_DW),
    .DEPTH(`FBPC_FIFO_DEPTH),
    .AW(`FBPC_FIFO_AW)
  ) u_rx_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_data(rx_data),
    .in_valid(rx_push),
    .in_ready(),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  ////////////////////////////////////////////////////////////////
  // sequencer
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      cur_slave <= 3'h0;
      bit_left <= 16'h0000;
      cycle_cnt <= 32'h0000_0000;
      slave_cnt <= 32'h0000_0000;
      refr_left <= 32'h0000_0000;
      req_active <= 1'b0;
      resp_window <= 1'b0;
      cycle_start <= 1'b0;
      refresh_pulse <= 1'b0;
      copy_open <= 1'b0;
      bus_cycle_time <= 32'h0000_0000;
      multi_master_cycle_time <= 32'h0000_0000;
      data_refresh_time <= 32'h0000_0000;
      per_slave_poll_time <= 32'h0000_0000;
    end else begin
      cycle_start <= 1'b0;
      refresh_pulse <= 1'b0;
      if (state != ST_IDLE) begin
        cycle_cnt <= cycle_cnt + 32'd1;
        slave_cnt <= slave_cnt + 32'd1;
      end
      if (state != ST_IDLE && bit_tick && bit_left != 16'h0000) begin
        bit_left <= bit_left - 16'd1;
      end
      case (state)
        ST_IDLE: begin
          if (enable && slave_count != 4'h0) begin
            cur_slave <= 3'h0;
            cycle_cnt <= 32'h0000_0000;
            slave_cnt <= 32'h0000_0000;
            cycle_start <= 1'b1;
            req_active <= 1'b1;
            bit_left <= ({8'h00, cur_out} + `FBPC_FRAME_OVH) * `FBPC_BYTE_BITS;
            state <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (bit_tick && bit_left == 16'd1) begin
            req_active <= 1'b0;
            resp_window <= 1'b1;
            bit_left <= cur_delay;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (bit_tick && bit_left <= 16'd1) begin
            bit_left <= ({8'h00, cur_in} + `FBPC_FRAME_OVH) * `FBPC_BYTE_BITS;
            state <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (bit_tick && bit_left == 16'd1) begin
            resp_window <= 1'b0;
            // poll time is request, slave delay and response only
            per_slave_poll_time <= slave_cnt + 32'd1;
            bit_left <= turn_bits(rate_sel);
            state <= ST_TURN;
          end
        end
        ST_TURN: begin
          if (bit_tick && bit_left == 16'd1) begin
            slave_cnt <= 32'h0000_0000;
            if (last_slave) begin
              refr_left <= refresh_us * `FBPC_CYC_PER_US;
              data_refresh_time <= refresh_us * `FBPC_CYC_PER_US;
              state <= ST_REFR;
            end else begin
              cur_slave <= cur_slave + 3'd1;
              req_active <= 1'b1;
              bit_left <= ({8'h00, out_bytes_flat[(cur_slave + 3'd1)*8 +: 8]} + `FBPC_FRAME_OVH)
                * `FBPC_BYTE_BITS;
              state <= ST_REQ;
            end
          end
        end
        ST_REFR: begin
          if (refr_left > 32'd1) begin
            refr_left <= refr_left - 32'd1;
          end else if (cycle_cnt + 32'd1 >= min_poll_interval) begin
            // cycle ends at larger of the two
            bus_cycle_time <= cycle_cnt + 32'd1;
            multi_master_cycle_time <= cycle_cnt + 32'd1 + other_masters_time;
            refresh_pulse <= 1'b1;
            copy_open <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      if (copy_open && !fifo_valid && state == ST_REQ) begin
        copy_open <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // host copy stage, drains fifo after each cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_valid <= 1'b0;
      host_data <= 8'h00;
    end else if (!host_valid || host_ready) begin
      // a taken byte is retired even after the copy window closes
      host_valid <= copy_open && fifo_valid;
      if (copy_open && fifo_valid) begin
        host_data <= fifo_data;
      end
    end
  end

  // ready is registered: it only rises when a byte pushed next edge still fits
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_level <= 4'h0;
      rx_ready <= 1'b0;
    end else begin
      rx_level <= next_rx_level;
      rx_ready <= resp_window && (next_rx_level < `FBPC_FIFO_DEPTH);
    end
  end
endmodule

// >>> verif/fbpc_poll_timer_properties.sv
/* checker: port timing relations of the poll timer.
 assumes: bound to fbpc_poll_timer, one clock, async low reset. */
`timescale 1ns/1ps
module fbpc_poll_timer_props (
  input wire clk,
  input wire rst_b,
  input wire [3:0] rate_sel,
  input wire compat_mode,
  input wire [3:0] slave_count,
  input wire [31:0] min_poll_interval,
  input wire [63:0] out_bytes_flat,
  input wire [63:0] in_bytes_flat,
  input wire [127:0] max_delay_flat,
  input wire [31:0] other_masters_time,
  input wire host_ready,
  input wire [2:0] cur_slave,
  input wire req_active,
  input wire resp_window,
  input wire cycle_start,
  input wire refresh_pulse,
  input wire [31:0] bus_cycle_time,
  input wire [31:0] multi_master_cycle_time,
  input wire [31:0] data_refresh_time,
  input wire host_valid,
  input wire [7:0] host_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // clocks per bit, rounded up at 200 MHz
  function [31:0] bit_clocks(input [3:0] r);
    case (r)
      4'h0: bit_clocks = 32'h5162;
      4'h1: bit_clocks = 32'h28B1;
      4'h2: bit_clocks = 32'h856;
      4'h3: bit_clocks = 32'h42B;
      4'h4: bit_clocks = 32'h190;
      4'h5: bit_clocks = 32'h86;
      4'h6: bit_clocks = 32'h43;
      4'h7: bit_clocks = 32'h22;
      default: bit_clocks = 32'h11;
    endcase
  endfunction
  wire [31:0] cpb = bit_clocks(rate_sel);
  wire [31:0] ob = {24'h0, out_bytes_flat[{cur_slave, 3'h0} +: 8]};
  wire [31:0] ib = {24'h0, in_bytes_flat[{cur_slave, 3'h0} +: 8]};
  wire [31:0] dl = {16'h0, max_delay_flat[{cur_slave, 4'h0} +: 16]};
  wire [31:0] req_exp = (ob + 32'h9) * 32'hB * cpb;
  wire [31:0] rsp_exp = (dl + (ib + 32'h9) * 32'hB) * cpb;
  reg [31:0] rcnt;
  reg [31:0] wcnt;
  reg [31:0] ccnt;
  // lengths of request, window and whole cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rcnt <= 32'h0;
      wcnt <= 32'h0;
      ccnt <= 32'h0;
    end else begin
      rcnt <= req_active ? rcnt + 32'h1 : 32'h0;
      wcnt <= resp_window ? wcnt + 32'h1 : 32'h0;
      ccnt <= cycle_start ? 32'h1 : ccnt + 32'h1;
    end
  end
  a_start_pulse: assert property (cycle_start |=> !cycle_start)
    else $error("cycle start wider than one clock");
  a_refresh_pulse: assert property (refresh_pulse |=> !refresh_pulse)
    else $error("refresh pulse wider than one clock");
  a_req_resp_apart: assert property (!(req_active && resp_window))
    else $error("request overlaps response window");
  a_slave_range: assert property (req_active |-> cur_slave < slave_count)
    else $error("polled station beyond configured count");
  a_req_length: assert property ($fell(req_active) |-> rcnt == req_exp)
    else $error("request frame length wrong");
  a_resp_length: assert property ($fell(resp_window) |-> wcnt == rsp_exp)
    else $error("response window length wrong");
  a_min_interval: assert property (refresh_pulse |-> ccnt + 32'h2 >= min_poll_interval)
    else $error("cycle shorter than minimum interval");
  a_refresh_time: assert property (refresh_pulse && !compat_mode |-> ##2 data_refresh_time == slave_count * 32'h7530)
    else $error("refresh figure wrong");
  a_multi_sum: assert property (refresh_pulse |-> ##2
    multi_master_cycle_time == bus_cycle_time + other_masters_time)
    else $error("shared bus figure wrong");
  a_host_hold: assert property (host_valid && !host_ready |=> host_valid && $stable(host_data))
    else $error("host byte dropped while stalled");
endmodule

// >>> verif/fbpc_slave_model.sv
/* slave station model: streams response bytes into the master.
 assumes: offers bytes only inside the response window unless stray. */
`timescale 1ns/1ps
module fbpc_slave_model (
  input wire clk,
  input wire rst_b,
  input wire resp_window,
  input wire rx_ready,
  input wire stray,
  output reg rx_valid,
  output reg [7:0] rx_data
);
  reg [7:0] exp_q[$];
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      exp_q.delete();
    end else begin
      if (rx_valid && rx_ready && resp_window)
        exp_q.push_back(rx_data);
      rx_valid <= resp_window || stray;
      // released line shows inverse, never the stale byte
      if (rx_valid && rx_ready && resp_window || !rx_valid)
        rx_data <= 8'($urandom);
      else if (!(resp_window || stray))
        rx_data <= ~rx_data;
    end
  end
endmodule

// >>> verif/fbpc_poll_timer_tb.sv
/* testbench: compat refresh with mid-cycle reset, then two poll cycles at the fastest rate.
 assumes: slave model on the receive side; host stalls then drains. */
`timescale 1ns/1ps
module fbpc_poll_timer_tb;
  reg clk = 1'b0;
  reg rst_b, enable, compat_mode, host_ready, stray, refused;
  reg [3:0] rate_sel, slave_count;
  reg [31:0] min_poll_interval, other_masters_time;
  reg [63:0] out_bytes_flat, in_bytes_flat;
  reg [127:0] max_delay_flat;
  wire rx_valid, req_active, resp_window, cycle_start, refresh_pulse, host_valid, rx_ready;
  wire [7:0] rx_data, host_data;
  wire [2:0] cur_slave;
  wire [31:0] bus_cycle_time, multi_master_cycle_time, data_refresh_time, per_slave_poll_time;
  int failures = 0, n_compared = 0, cyc = 0, t0 = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  fbpc_poll_timer u_dut (.clk(clk), .rst_b(rst_b), .enable(enable), .rate_sel(rate_sel),
    .compat_mode(compat_mode), .slave_count(slave_count), .min_poll_interval(min_poll_interval),
    .out_bytes_flat(out_bytes_flat), .in_bytes_flat(in_bytes_flat), .max_delay_flat(max_delay_flat),
    .other_masters_time(other_masters_time), .rx_valid(rx_valid), .rx_data(rx_data),
    .host_ready(host_ready), .cur_slave(cur_slave), .req_active(req_active), .resp_window(resp_window),
    .cycle_start(cycle_start), .refresh_pulse(refresh_pulse), .bus_cycle_time(bus_cycle_time),
    .multi_master_cycle_time(multi_master_cycle_time), .data_refresh_time(data_refresh_time),
    .per_slave_poll_time(per_slave_poll_time), .host_valid(host_valid), .host_data(host_data),
    .rx_ready(rx_ready));
  fbpc_slave_model u_slv (.clk(clk), .rst_b(rst_b), .resp_window(resp_window), .rx_ready(rx_ready),
    .stray(stray), .rx_valid(rx_valid), .rx_data(rx_data));
  task check(input string what, input [31:0] seen, input [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task summarize;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // bounded wait for start (0), refresh pulse (1) or refresh figure (2)
  task wait_pulse(input int which, input int limit);
    int n;
    n = 0;
    while ((which == 0 ? cycle_start : (which == 1 ? refresh_pulse : |data_refresh_time)) !== 1'b1
      && n < limit) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= limit) failures++;
  endtask
  // one cycle, then its length against the expected period
  task run_cycle(input [31:0] period);
    enable = 1'b1;
    wait_pulse(0, 20);
    t0 = cyc;
    enable = 1'b0;
    wait_pulse(1, 60000);
    check("cycle length", (cyc - t0 + 3 >= period) && (cyc - t0 <= period + 3), 32'h1);
    repeat (3) @(posedge clk);
    #1;
  endtask
  // monitor: host bytes against what the slave delivered
  always @(posedge clk) begin
    if (host_valid === 1'b1 && host_ready === 1'b1) begin
      if (u_slv.exp_q.size() == 0) check("host extra", 32'h1, 32'h0);
      else check("host byte", {24'h0, host_data}, {24'h0, u_slv.exp_q.pop_front()});
    end
    if (resp_window === 1'b1 && rx_valid && rx_ready === 1'b0) refused <= 1'b1;
  end
  initial begin
    #625000;
    failures++;
    summarize;
  end
  initial begin
    {rst_b, enable, compat_mode, host_ready, stray, refused} = 6'h0;
    rate_sel = 4'h8;
    slave_count = 4'h1;
    min_poll_interval = 32'h64;
    other_masters_time = 32'h4D2;
    out_bytes_flat = 64'h2;
    in_bytes_flat = 64'h2;
    max_delay_flat = 128'h14;
    void'($urandom(1622));
    repeat (4) @(posedge clk);
    #1;
    rst_b = 1'b1;
    // compat figure set at last turnaround; cycle then cut by a reset
    compat_mode = 1'b1;
    enable = 1'b1;
    wait_pulse(0, 20);
    enable = 1'b0;
    wait_pulse(2, 20000);
    check("compat refresh", data_refresh_time, 32'h68FB0);
    check("poll time", per_slave_poll_time, 32'h1166);
    rst_b = 1'b0;
    compat_mode = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    check("reset refresh", data_refresh_time, 32'h0);
    refused = 1'b0;
    // host stalled: fifo fills until refused
    run_cycle(32'hBBB6);
    check("poll time", per_slave_poll_time, 32'h1166);
    check("cycle time", bus_cycle_time, 32'hBBB6);
    check("refresh time", data_refresh_time, 32'h7530);
    check("shared time", multi_master_cycle_time, 32'hC088);
    check("fifo refused", {31'h0, refused}, 32'h1);
    // stray bytes outside the window must not land
    min_poll_interval = 32'hBBE4;
    stray = 1'b1;
    repeat (200) begin
      @(posedge clk);
      #1;
      host_ready = $urandom % 2;
    end
    stray = 1'b0;
    host_ready = 1'b1;
    // minimum interval dominates the summed times
    run_cycle(32'hBBE4);
    check("cycle time", bus_cycle_time, 32'hBBE4);
    repeat (50) @(posedge clk);
    check("bytes left", u_slv.exp_q.size(), 32'h0);
    summarize;
  end
endmodule
bind fbpc_poll_timer fbpc_poll_timer_props u_props (.clk(clk), .rst_b(rst_b), .rate_sel(rate_sel),
  .compat_mode(compat_mode), .slave_count(slave_count), .min_poll_interval(min_poll_interval),
  .out_bytes_flat(out_bytes_flat), .in_bytes_flat(in_bytes_flat), .max_delay_flat(max_delay_flat),
  .other_masters_time(other_masters_time), .host_ready(host_ready), .cur_slave(cur_slave),
  .req_active(req_active), .resp_window(resp_window), .cycle_start(cycle_start),
  .refresh_pulse(refresh_pulse), .bus_cycle_time(bus_cycle_time),
  .multi_master_cycle_time(multi_master_cycle_time), .data_refresh_time(data_refresh_time),
  .host_valid(host_valid), .host_data(host_data));
